/* File: qcs_pkg.sv */
// shared constants for the quadrature capture and status latch block
package qcs_pkg;

	// register offsets as seen on the plain register port
	localparam logic [7:0] QCS_OFS_STATUS   = 8'h38;
	localparam logic [7:0] QCS_OFS_TIMER    = 8'h3A;
	localparam logic [7:0] QCS_OFS_PERIOD   = 8'h3C;
	localparam logic [7:0] QCS_OFS_TMR_SNAP = 8'h3E;
	localparam logic [7:0] QCS_OFS_PRD_SNAP = 8'h40;
	localparam logic [7:0] QCS_OFS_REV      = 8'h5C;
	localparam logic [7:0] QCS_OFS_CTRL     = 8'h60;
	localparam logic [7:0] QCS_OFS_IRQ_STS  = 8'h64;
	localparam logic [7:0] QCS_OFS_IRQ_MASK = 8'h68;

	// encoder_status field positions
	localparam int QCS_ST_UPEV  = 7;
	localparam int QCS_ST_FDIR  = 6;
	localparam int QCS_ST_LDIR  = 5;
	localparam int QCS_ST_IDIR  = 4;
	localparam int QCS_ST_COVF  = 3;
	localparam int QCS_ST_CDIR  = 2;
	localparam int QCS_ST_FIDX  = 1;
	localparam int QCS_ST_PERR  = 0;

	// control register fields: enable bit and prescale exponent
	localparam int QCS_CT_EN    = 0;
	localparam int QCS_CT_PRE_LO = 4;
	localparam int QCS_CT_PRE_HI = 6;

	// interrupt status / mask bit positions
	localparam int QCS_IRQ_UPEV = 0;
	localparam int QCS_IRQ_COVF = 1;
	localparam int QCS_IRQ_CDIR = 2;
	localparam int QCS_IRQ_FIDX = 3;

	// reset values
	localparam logic [15:0] QCS_RST_WORD  = 16'h0000;
	localparam logic [3:0]  QCS_RST_CTRL  = 4'h1;
	localparam logic [6:0]  QCS_RST_DIV   = 7'h00;
	localparam logic [31:0] QCS_REV_VALUE = 32'h0000_0100; // value is arbitrary
	localparam logic [15:0] QCS_TMR_MAX   = 16'hFFFF;

endpackage

/* File: qcs_sticky.sv */
// one sticky flag: hardware sets, software clears by writing one
module qcs_sticky (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// set and clear
	input  wire logic set,
	input  wire logic clr,
	// flag
	output logic      flag_q
);

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end

endmodule

/* File: qcs_ctimer.sv */
// 16-bit capture timer with restart, software load and overflow pulse
module qcs_ctimer
	import qcs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// controls
	input  wire logic        tick,
	input  wire logic        restart,
	input  wire logic        load,
	input  wire logic [15:0] load_data,
	// state
	output logic [15:0]      count_q,
	output logic             ovf_q
);

	// software load beats restart; restart beats counting
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= QCS_RST_WORD;
		end else if (load) begin
			count_q <= load_data;
		end else if (restart) begin
			count_q <= QCS_RST_WORD;
		end else if (tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// one-cycle pulse when the count wraps from all ones
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= tick && !load && !restart && (count_q == QCS_TMR_MAX);
		end
	end

endmodule

/* File: qcs_latch.sv */
// status flags, capture timing and register port of the encoder capture block
//
// Contract
// R1 - unit position event sets sticky bit 7
// R2 - first index latches direction into bit 6
// R3 - bit 5 shows live direction
// R4 - every index latches direction into bit 4
// R5 - bits 3..1 sticky, write one clears
// R6 - capture timer overflow sets bit 3
// R7 - direction change between captures sets bit 2
// R8 - first index pulse sets bit 1
// R9 - bit 0 rewritten with error each index
// R10 - 16-bit read/write capture timer time base
// R11 - period register holds count between events
// R12 - timer snapshot on timeout or position read
// R13 - period snapshot on timeout or position read
// R14 - status at 38h, resets to zero
// R15 - capture event moves count, restarts timer
// R16 - zero writes and read-only writes ignored
module qcs_latch
	import qcs_pkg::*;
#(
	parameter logic [31:0] REV_ID = QCS_REV_VALUE
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata_q,
	// events from the rest of the encoder unit
	input  wire logic        dir_fwd,
	input  wire logic        index_event,
	input  wire logic        index_err,
	input  wire logic        unit_pos_event,
	input  wire logic        capture_event,
	input  wire logic        unit_timeout,
	input  wire logic        pos_cnt_read,
	// interrupt
	output logic             irq
);

	// decoded register writes
	logic        wr_status;
	logic        wr_timer;
	logic        wr_period;
	logic        wr_prd_snap;
	logic        wr_ctrl;
	logic        wr_irq_sts;
	logic        wr_irq_mask;

	// status state
	logic        unit_pos_event_flag;
	logic        capture_overflow_err;
	logic        capture_dir_err;
	logic        first_index_seen;
	logic        first_index_dir_flag_q;
	logic        index_dir_latch_flag_q;
	logic        pos_count_err_flag_q;
	logic        first_done_q;
	logic        dir_prev_q;
	logic        dir_moved_q;
	logic        dir_armed_q;
	logic        cap_dir_err_set;
	logic [15:0] encoder_status;

	// capture timing state
	logic [3:0]  ctrl_q;
	logic [6:0]  div_q;
	logic [6:0]  div_lim;
	logic        cap_tick;
	logic        snap_take;
	logic [15:0] capture_timer;
	logic        timer_ovf;
	logic [15:0] capture_period_q;
	logic [15:0] capture_timer_snapshot_q;
	logic [15:0] capture_period_snapshot_q;

	// interrupt state
	logic [3:0]  irq_evt;
	logic [3:0]  irq_sts_q;
	logic [3:0]  irq_mask_q;

	// write decode; strobes are single cycle so no edge detect needed
	assign wr_status   = reg_wr && (reg_addr == QCS_OFS_STATUS);
	assign wr_timer    = reg_wr && (reg_addr == QCS_OFS_TIMER);
	assign wr_period   = reg_wr && (reg_addr == QCS_OFS_PERIOD);
	assign wr_prd_snap = reg_wr && (reg_addr == QCS_OFS_PRD_SNAP);
	assign wr_ctrl     = reg_wr && (reg_addr == QCS_OFS_CTRL);
	assign wr_irq_sts  = reg_wr && (reg_addr == QCS_OFS_IRQ_STS);
	assign wr_irq_mask = reg_wr && (reg_addr == QCS_OFS_IRQ_MASK);

	// sticky flags; only a one written to the bit clears it
	qcs_sticky u_upev (
		.clk     (clk),
		.reset_n (reset_n),
		.set     (unit_pos_event),                           // [R1]
		.clr     (wr_status && reg_wdata[QCS_ST_UPEV]),      // [R1] [R16]
		.flag_q  (unit_pos_event_flag)
	);

	qcs_sticky u_covf (
		.clk     (clk),
		.reset_n (reset_n),
		.set     (timer_ovf),                                // [R6]
		.clr     (wr_status && reg_wdata[QCS_ST_COVF]),      // [R5] [R16]
		.flag_q  (capture_overflow_err)
	);

	qcs_sticky u_cdir (
		.clk     (clk),
		.reset_n (reset_n),
		.set     (cap_dir_err_set),                          // [R7]
		.clr     (wr_status && reg_wdata[QCS_ST_CDIR]),      // [R5] [R16]
		.flag_q  (capture_dir_err)
	);

	qcs_sticky u_fidx (
		.clk     (clk),
		.reset_n (reset_n),
		.set     (index_event && !first_done_q),             // [R8]
		.clr     (wr_status && reg_wdata[QCS_ST_FIDX]),      // [R5] [R16]
		.flag_q  (first_index_seen)
	);

	// first index is remembered apart from its flag so a clear does not re-arm it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_done_q           <= 1'b0;
			first_index_dir_flag_q <= 1'b0;
		end else if (index_event && !first_done_q) begin
			first_done_q           <= 1'b1;
			first_index_dir_flag_q <= dir_fwd;               // [R2]
		end
	end

	// direction and error latched on every index event
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			index_dir_latch_flag_q <= 1'b0;
			pos_count_err_flag_q   <= 1'b0;
		end else if (index_event) begin
			index_dir_latch_flag_q <= dir_fwd;               // [R4]
			pos_count_err_flag_q   <= index_err;             // [R9]
		end
	end

	// any direction change since the last capture event is remembered;
	// compare armed one cycle after reset so a forward start is no false change
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dir_prev_q  <= 1'b0;
			dir_moved_q <= 1'b0;
			dir_armed_q <= 1'b0;
		end else begin
			dir_prev_q  <= dir_fwd;
			dir_armed_q <= 1'b1;
			if (capture_event) begin
				dir_moved_q <= 1'b0;
			end else if (dir_armed_q && (dir_fwd != dir_prev_q)) begin
				dir_moved_q <= 1'b1;
			end
		end
	end

	// a change in the same cycle as the capture still counts
	assign cap_dir_err_set = capture_event
		&& (dir_moved_q || (dir_armed_q && (dir_fwd != dir_prev_q))); // [R7]

	// status word; upper byte reserved reads zero, bit 5 is live
	always_comb begin
		encoder_status              = QCS_RST_WORD;          // [R14]
		encoder_status[QCS_ST_UPEV] = unit_pos_event_flag;
		encoder_status[QCS_ST_FDIR] = first_index_dir_flag_q;
		encoder_status[QCS_ST_LDIR] = dir_fwd;               // [R3]
		encoder_status[QCS_ST_IDIR] = index_dir_latch_flag_q;
		encoder_status[QCS_ST_COVF] = capture_overflow_err;
		encoder_status[QCS_ST_CDIR] = capture_dir_err;
		encoder_status[QCS_ST_FIDX] = first_index_seen;
		encoder_status[QCS_ST_PERR] = pos_count_err_flag_q;
	end

	// control: timer enable and prescale exponent
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= QCS_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= {reg_wdata[QCS_CT_PRE_HI:QCS_CT_PRE_LO], reg_wdata[QCS_CT_EN]};
		end
	end

	// prescale divider gives the timer a one-cycle enable, never a second clock
	assign div_lim  = (7'h01 << ctrl_q[3:1]) - 7'h01;
	assign cap_tick = ctrl_q[0] && (div_q >= div_lim);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= QCS_RST_DIV;
		end else if (!ctrl_q[0] || cap_tick || capture_event) begin
			div_q <= QCS_RST_DIV;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end

	// capture timer: software writable time base, restarted per capture
	qcs_ctimer u_timer (
		.clk       (clk),
		.reset_n   (reset_n),
		.tick      (cap_tick),                               // [R10]
		.restart   (capture_event),                          // [R15]
		.load      (wr_timer),                               // [R10]
		.load_data (reg_wdata[15:0]),
		.count_q   (capture_timer),
		.ovf_q     (timer_ovf)
	);

	// period takes the elapsed count at each capture; a software write wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_period_q <= QCS_RST_WORD;
		end else if (wr_period) begin
			capture_period_q <= reg_wdata[15:0];
		end else if (capture_event) begin
			capture_period_q <= capture_timer;               // [R11] [R15]
		end
	end

	// both snapshots move together so software sees a coherent pair
	assign snap_take = unit_timeout || pos_cnt_read;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_timer_snapshot_q <= QCS_RST_WORD;
		end else if (snap_take) begin
			capture_timer_snapshot_q <= capture_timer;       // [R12]
		end
	end

	// period snapshot is writable; a hardware snapshot beats the write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_period_snapshot_q <= QCS_RST_WORD;
		end else if (snap_take) begin
			capture_period_snapshot_q <= capture_period_q;   // [R13]
		end else if (wr_prd_snap) begin
			capture_period_snapshot_q <= reg_wdata[15:0];
		end
	end

	// interrupt sources: the sticky flag events
	assign irq_evt = {index_event && !first_done_q, cap_dir_err_set, timer_ovf, unit_pos_event};

	// set beats write-one-to-clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_sts_q <= 4'h0;
		end else begin
			irq_sts_q <= irq_evt | (irq_sts_q & ~(wr_irq_sts ? reg_wdata[3:0] : 4'h0));
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_q <= 4'h0;
		end else if (wr_irq_mask) begin
			irq_mask_q <= reg_wdata[3:0];
		end
	end

	// level interrupt while any unmasked bit stands
	assign irq = |(irq_sts_q & irq_mask_q);

	// read data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				QCS_OFS_STATUS:   reg_rdata_q <= {16'h0000, encoder_status};
				QCS_OFS_TIMER:    reg_rdata_q <= {16'h0000, capture_timer};
				QCS_OFS_PERIOD:   reg_rdata_q <= {16'h0000, capture_period_q};
				QCS_OFS_TMR_SNAP: reg_rdata_q <= {16'h0000, capture_timer_snapshot_q};
				QCS_OFS_PRD_SNAP: reg_rdata_q <= {16'h0000, capture_period_snapshot_q};
				QCS_OFS_REV:      reg_rdata_q <= REV_ID;
				QCS_OFS_CTRL:     reg_rdata_q <= {25'h0, ctrl_q[3:1], 3'h0, ctrl_q[0]};
				QCS_OFS_IRQ_STS:  reg_rdata_q <= {28'h0, irq_sts_q};
				QCS_OFS_IRQ_MASK: reg_rdata_q <= {28'h0, irq_mask_q};
				default:          reg_rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_first_idx;
		index_event && !first_done_q;
	endsequence

	sequence s_capture;
		capture_event && !wr_timer && !wr_period;
	endsequence

	upev_set_a: assert property (unit_pos_event |=> encoder_status[QCS_ST_UPEV]) // [R1]
		else $error("unit position flag not set");
	first_dir_a: assert property (s_first_idx |=> // [R2]
		(encoder_status[QCS_ST_FDIR] == $past(dir_fwd)) && encoder_status[QCS_ST_FIDX])
		else $error("first index direction not latched");
	first_hold_a: assert property (first_done_q |=> $stable(first_index_dir_flag_q)) // [R2]
		else $error("first index direction changed later");
	idx_dir_a: assert property (index_event |=> // [R4]
		encoder_status[QCS_ST_IDIR] == $past(dir_fwd)) else $error("index direction wrong");
	perr_a: assert property (index_event |=> // [R9]
		encoder_status[QCS_ST_PERR] == $past(index_err)) else $error("count error wrong");
	sticky_hold_a: assert property (capture_overflow_err && !(wr_status
		&& reg_wdata[QCS_ST_COVF]) |=> capture_overflow_err) // [R5]
		else $error("sticky flag lost");
	zero_write_a: assert property (wr_status && !reg_wdata[QCS_ST_CDIR] && capture_dir_err
		|=> capture_dir_err) // [R16]
		else $error("zero write cleared flag");
	ovf_flag_a: assert property (cap_tick && capture_timer == QCS_TMR_MAX && !wr_timer
		&& !capture_event |=> ##1 capture_overflow_err) // [R6]
		else $error("overflow flag missed");
	period_a: assert property (s_capture |=> // [R11]
		capture_period_q == $past(capture_timer) && capture_timer == 16'h0000) // [R15]
		else $error("period capture wrong");
	snap_a: assert property (snap_take |=> capture_timer_snapshot_q == $past(capture_timer)
		&& capture_period_snapshot_q == $past(capture_period_q)) // [R12]
		else $error("snapshot wrong");
	cdir_a: assert property (cap_dir_err_set |=> capture_dir_err) // [R7]
		else $error("direction error missed");
	rd_once_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000) // [R14]
		else $error("read data outside its cycle");
	// read-only snapshot moves only when hardware takes one
	tmr_ro_a: assert property (reg_wr && reg_addr == QCS_OFS_TMR_SNAP && !snap_take // [R16]
		|=> $stable(capture_timer_snapshot_q)) else $error("read-only snapshot written");
	perr_hold_a: assert property (!index_event |=> $stable(pos_count_err_flag_q)) // [R9]
		else $error("count error changed between index events");
	// clearing the first index flag must not re-arm it
	fidx_once_a: assert property (first_done_q && !first_index_seen // [R8]
		|=> !first_index_seen) else $error("first index flag set again");

endmodule

/* File: qcs_enc_model.sv */
// quadrature encoder far side: direction level and event pulses toward the block
module qcs_enc_model (
	// clock
	input  wire logic clk,
	// direction and events
	output logic      dir_fwd,
	output logic      index_event,
	output logic      index_err,
	output logic      unit_pos_event,
	output logic      capture_event,
	output logic      unit_timeout,
	output logic      pos_cnt_read
);
	timeunit 1ns;
	timeprecision 100ps;

	// quiet lines at time zero; error line starts at a value that means nothing
	initial begin
		dir_fwd = 1'h0;
		index_event = 1'h0;
		index_err = 1'h1;
		unit_pos_event = 1'h0;
		capture_event = 1'h0;
		unit_timeout = 1'h0;
		pos_cnt_read = 1'h0;
	end

	// direction changes just after an edge, as the decoder would
	task automatic set_dir(input logic d);
		@(posedge clk);
		dir_fwd <= d;
	endtask

	// one-cycle pulse: 0 index, 1 unit pos, 2 capture, 3 timeout, 4 counter read
	task automatic pulse(input int kind, input logic err);
		@(posedge clk);
		index_err <= err;
		case (kind)
			0: index_event <= 1'h1;
			1: unit_pos_event <= 1'h1;
			2: capture_event <= 1'h1;
			3: unit_timeout <= 1'h1;
			default: pos_cnt_read <= 1'h1;
		endcase
		@(posedge clk);
		{index_event, unit_pos_event, capture_event, unit_timeout, pos_cnt_read} <= 5'h00;
		// error only means something beside an index; flip it so stale values cannot help
		index_err <= ~err;
	endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the capture and status latch block
module testbench;
	import qcs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [31:0] TB_REV = 32'h0000_0A5C; // value is arbitrary

	// design ports
	logic        clk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata_q;
	logic        dir_fwd;
	logic        index_event;
	logic        index_err;
	logic        unit_pos_event;
	logic        capture_event;
	logic        unit_timeout;
	logic        pos_cnt_read;
	logic        irq;
	int          mismatches;
	int          checks;

	qcs_latch #(.REV_ID(TB_REV)) qcs_latch_inst (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .dir_fwd(dir_fwd),
		.index_event(index_event), .index_err(index_err), .unit_pos_event(unit_pos_event),
		.capture_event(capture_event), .unit_timeout(unit_timeout),
		.pos_cnt_read(pos_cnt_read), .irq(irq)
	);

	qcs_enc_model qcs_enc_model_inst (
		.clk(clk), .dir_fwd(dir_fwd), .index_event(index_event), .index_err(index_err),
		.unit_pos_event(unit_pos_event), .capture_event(capture_event),
		.unit_timeout(unit_timeout), .pos_cnt_read(pos_cnt_read)
	);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// verdict and end of run, shared by the main sequence and the watchdog
	task automatic finish_test;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// register value compare
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t reg %h got %h exp %h", $time, a, got, exp);
		end
	endtask

	// interrupt level compare, sampled mid-cycle once register updates have landed
	task automatic chk_irq(input logic exp);
		@(negedge clk);
		checks++;
		if (irq !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t irq got %b exp %b", $time, irq, exp);
		end
	endtask

	// one-cycle write strobe; a gap edge follows before the next access
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	// one-cycle read strobe; data stands only in the following cycle
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(negedge clk);
		chk_reg(a, reg_rdata_q, exp);
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		finish_test();
	end

	// main sequence
	initial begin
		clk = 1'h0;
		reset_n = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		mismatches = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		// reset values, identity, unmapped place
		rchk(QCS_OFS_STATUS, 32'h0000_0000);
		rchk(QCS_OFS_PERIOD, 32'h0000_0000);
		rchk(QCS_OFS_TMR_SNAP, 32'h0000_0000);
		rchk(QCS_OFS_PRD_SNAP, 32'h0000_0000);
		rchk(QCS_OFS_REV, TB_REV);
		rchk(QCS_OFS_CTRL, 32'h0000_0001);
		rchk(8'h70, 32'h0000_0000);
		// stop the time base so counts stay put, then read/write registers
		wr(QCS_OFS_CTRL, 32'h0000_0000);
		wr(QCS_OFS_TIMER, 32'hFFFF_1234);
		rchk(QCS_OFS_TIMER, 32'h0000_1234);
		wr(QCS_OFS_PERIOD, 32'h0000_00AB);
		rchk(QCS_OFS_PERIOD, 32'h0000_00AB);
		wr(QCS_OFS_TMR_SNAP, 32'h0000_5A5A);
		rchk(QCS_OFS_TMR_SNAP, 32'h0000_0000);
		wr(QCS_OFS_PRD_SNAP, 32'h0000_0055);
		rchk(QCS_OFS_PRD_SNAP, 32'h0000_0055);
		// snapshots on unit timeout and on a position counter read
		qcs_enc_model_inst.pulse(3, 1'h0);
		rchk(QCS_OFS_TMR_SNAP, 32'h0000_1234);
		rchk(QCS_OFS_PRD_SNAP, 32'h0000_00AB);
		wr(QCS_OFS_TIMER, 32'h0000_2222);
		qcs_enc_model_inst.pulse(4, 1'h0);
		rchk(QCS_OFS_TMR_SNAP, 32'h0000_2222);
		rchk(QCS_OFS_PRD_SNAP, 32'h0000_00AB);
		// capture moves the count into the period and restarts the timer
		qcs_enc_model_inst.pulse(2, 1'h0);
		rchk(QCS_OFS_PERIOD, 32'h0000_2222);
		rchk(QCS_OFS_TIMER, 32'h0000_0000);
		rchk(QCS_OFS_STATUS, 32'h0000_0000);
		// direction change between captures
		qcs_enc_model_inst.set_dir(1'h1);
		rchk(QCS_OFS_STATUS, 32'h0000_0020);
		qcs_enc_model_inst.pulse(2, 1'h0);
		rchk(QCS_OFS_STATUS, 32'h0000_0024);
		wr(QCS_OFS_STATUS, 32'h0000_0000);
		rchk(QCS_OFS_STATUS, 32'h0000_0024);
		wr(QCS_OFS_STATUS, 32'h0000_0004);
		rchk(QCS_OFS_STATUS, 32'h0000_0020);
		// index events: first-index latch, per-index latch, error rewrite
		qcs_enc_model_inst.pulse(0, 1'h1);
		rchk(QCS_OFS_STATUS, 32'h0000_0073);
		qcs_enc_model_inst.set_dir(1'h0);
		qcs_enc_model_inst.pulse(0, 1'h0);
		rchk(QCS_OFS_STATUS, 32'h0000_0042);
		wr(QCS_OFS_STATUS, 32'h0000_FFF1);
		rchk(QCS_OFS_STATUS, 32'h0000_0042);
		wr(QCS_OFS_STATUS, 32'h0000_0002);
		rchk(QCS_OFS_STATUS, 32'h0000_0040);
		qcs_enc_model_inst.pulse(0, 1'h0);
		rchk(QCS_OFS_STATUS, 32'h0000_0040);
		// unit position event, interrupt raised, masked and cleared
		qcs_enc_model_inst.pulse(1, 1'h0);
		rchk(QCS_OFS_STATUS, 32'h0000_00C0);
		chk_irq(1'h0);
		wr(QCS_OFS_IRQ_MASK, 32'h0000_0001);
		chk_irq(1'h1);
		wr(QCS_OFS_IRQ_STS, 32'h0000_0001);
		chk_irq(1'h0);
		wr(QCS_OFS_STATUS, 32'h0000_0080);
		rchk(QCS_OFS_STATUS, 32'h0000_0040);
		// overflow: run the timer across the wrap, then stop it
		wr(QCS_OFS_TIMER, 32'h0000_FFFE);
		wr(QCS_OFS_CTRL, 32'h0000_0001);
		repeat (6) @(posedge clk);
		wr(QCS_OFS_CTRL, 32'h0000_0000);
		rchk(QCS_OFS_STATUS, 32'h0000_0048);
		wr(QCS_OFS_STATUS, 32'h0000_0008);
		rchk(QCS_OFS_STATUS, 32'h0000_0040);
		// interrupt status keeps overflow, direction error and first index
		rchk(QCS_OFS_IRQ_STS, 32'h0000_000E);
		rchk(QCS_OFS_IRQ_MASK, 32'h0000_0001);
		// prescale exponent 1: the time base advances every second clock
		wr(QCS_OFS_TIMER, 32'h0000_0000);
		wr(QCS_OFS_CTRL, 32'h0000_0011);
		rchk(QCS_OFS_CTRL, 32'h0000_0011);
		wr(QCS_OFS_CTRL, 32'h0000_0000);
		rchk(QCS_OFS_TIMER, 32'h0000_0002);
		finish_test();
	end
endmodule
